/* File: rtl/dpz_pkg.sv */
// Operation
// - CKE low with NOP enters power-down
// - Accept CKE low during activate/precharge/refresh
// - Bank state picks precharge or active mode
// - Entry disables buffers except clock, ODT, CKE, reset
// - Receivers off after tCPDED of NOP
// - A12 and banks choose fast or slow exit
// - DLL off only in slow-exit precharge mode
// - Reset low ends power-down into reset
// - CKE high with NOP exits; tXP/tXPDLL
// - First long calibration tZQinit, later tZQoper
// - Long calibration runs engine, then loads values
// - Short calibration completes within tZQCS
package dpz_pkg;

  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    DPZ_CMD_NOP,
    DPZ_CMD_ACT,
    DPZ_CMD_PRE,
    DPZ_CMD_REF,
    DPZ_CMD_RD,
    DPZ_CMD_MRS,
    DPZ_CMD_ZQCL,
    DPZ_CMD_ZQCS
  } dpz_cmd_t;

  typedef struct packed {
    logic [CNT_W-1:0] t_xp;
    logic [CNT_W-1:0] t_xpdll;
    logic [CNT_W-1:0] t_cpded;
    logic [CNT_W-1:0] t_rfc;
    logic [CNT_W-1:0] t_zqinit;
    logic [CNT_W-1:0] t_zqoper;
    logic [CNT_W-1:0] t_zqcs;
  } dpz_timing_t;

  typedef struct packed {
    logic     cke;
    dpz_cmd_t cmd;
  } dpz_cmdbus_t;

  localparam logic [CNT_W-1:0] CNT_RST      = 16'h0000;
  localparam logic [3:0]       INIT_DLY_RST = 4'h0;

endpackage : dpz_pkg

/* File: rtl/dpz_cnt.sv */
`timescale 1ns/100ps
module dpz_cnt
  import dpz_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] value,
  output logic                  busy
);
  logic [CNT_W-1:0] cnt_r;

  // Countdown; load restarts, busy while nonzero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= CNT_RST;
    end else if (load) begin
      cnt_r <= value;
    end else if (cnt_r != CNT_RST) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  assign busy = (cnt_r != CNT_RST);
endmodule : dpz_cnt

/* File: rtl/dpz_zq.sv */
`timescale 1ns/100ps
module dpz_zq
  import dpz_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        start_long,
  input  wire logic        start_short,
  input  wire dpz_timing_t tim,
  output logic             busy,
  output logic             done
);
  logic             first_r;
  logic [CNT_W-1:0] cnt_r;
  logic             busy_r;

  // First long calibration after reset gets the longer window
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_r <= 1'b1;
    end else if (start_long && !busy_r) begin
      first_r <= 1'b0;
    end
  end

  // Engine runs; on the last cycle values move to the I/O
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r  <= CNT_RST;
      busy_r <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy_r && start_long) begin
        cnt_r  <= first_r ? tim.t_zqinit : tim.t_zqoper;
        busy_r <= 1'b1;
      end else if (!busy_r && start_short) begin
        cnt_r  <= tim.t_zqcs;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r <= 16'h0001) begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end

  assign busy = busy_r;
endmodule : dpz_zq

/* File: rtl/dpz_pd_ctrl.sv */
`timescale 1ns/100ps
module dpz_pd_ctrl
  import dpz_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        cke_pin,
  input  wire logic [2:0]  cmd_pin,
  input  wire logic        any_bank_open,
  input  wire logic        bank_op_busy,
  input  wire logic        mr0_a12,
  input  wire logic        dll_locked,
  input  wire dpz_timing_t tim,
  output logic             pd_active_r,
  output logic             pd_precharge_r,
  output logic             pd_pending_r,
  output logic             buffers_on_r,
  output logic             cmd_rcv_on_r,
  output logic             dll_on_r,
  output logic             dll_reset_req_r,
  output logic             xp_busy_r,
  output logic             xpdll_busy_r,
  output logic             zq_busy_r,
  output logic             zq_done_r
);
  typedef enum logic [1:0] {
    DPZ_ST_RUN,
    DPZ_ST_ENTER,
    DPZ_ST_PD
  } dpz_state_t;

  dpz_state_t  state_r;
  dpz_cmdbus_t s1_r;
  dpz_cmdbus_t s2_r;
  logic        cke_d_r;
  logic        dll_was_locked_r;
  logic        exit_ev;
  logic        enter_ev;
  logic        cpded_busy;
  logic        xp_busy;
  logic        xpdll_busy;
  logic        zq_busy;
  logic        zq_done;
  logic        slow_mode;
  logic        rfc_busy;
  logic        op_busy;

  function automatic logic is_nop(input dpz_cmd_t c);
    is_nop = (c == DPZ_CMD_NOP);
  endfunction : is_nop

  // Pins cross into sys_clk before any decode
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r    <= '0;
      s2_r    <= '0;
      cke_d_r <= 1'b0;
    end else begin
      s1_r    <= {cke_pin, dpz_cmd_t'(cmd_pin)};
      s2_r    <= s1_r;
      cke_d_r <= s2_r.cke;
    end
  end

  // Entry needs falling CKE with NOP; exit rising CKE with NOP
  assign enter_ev = (state_r == DPZ_ST_RUN) && cke_d_r && !s2_r.cke
                    && is_nop(s2_r.cmd);
  assign exit_ev  = (state_r != DPZ_ST_RUN) && !cke_d_r && s2_r.cke
                    && is_nop(s2_r.cmd);
  assign slow_mode = !any_bank_open && !mr0_a12;

  dpz_cnt u_cpded (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .load    (enter_ev),
    .value   (tim.t_cpded),
    .busy    (cpded_busy)
  );

  dpz_cnt u_xp (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .load    (exit_ev),
    .value   (tim.t_xp),
    .busy    (xp_busy)
  );

  // Slow exit or DLL reach window; entry does not wait for it
  dpz_cnt u_xpdll (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .load    (exit_ev),
    .value   (tim.t_xpdll),
    .busy    (xpdll_busy)
  );

  // Own refresh keeps power-down pending until tRFC ends
  dpz_cnt u_rfc (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .load    (state_r == DPZ_ST_RUN && s2_r.cke
              && s2_r.cmd == DPZ_CMD_REF),
    .value   (tim.t_rfc),
    .busy    (rfc_busy)
  );

  assign op_busy = bank_op_busy || rfc_busy;

  dpz_zq u_zq (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .start_long  (state_r == DPZ_ST_RUN && s2_r.cke
                  && s2_r.cmd == DPZ_CMD_ZQCL),
    .start_short (state_r == DPZ_ST_RUN && s2_r.cke
                  && s2_r.cmd == DPZ_CMD_ZQCS),
    .tim         (tim),
    .busy        (zq_busy),
    .done        (zq_done)
  );

  // Reset low leaves power-down at once
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= DPZ_ST_RUN;
    end else begin
      case (state_r)
        DPZ_ST_RUN: begin
          if (enter_ev) begin
            state_r <= DPZ_ST_ENTER;
          end
        end
        DPZ_ST_ENTER: begin
          if (exit_ev) begin
            state_r <= DPZ_ST_RUN;
          end else if (!op_busy && !cpded_busy) begin
            state_r <= DPZ_ST_PD;
          end
        end
        DPZ_ST_PD: begin
          if (exit_ev) begin
            state_r <= DPZ_ST_RUN;
          end
        end
        default: begin
          state_r <= DPZ_ST_RUN;
        end
      endcase
    end
  end

  // Mode decided once in-progress work has finished
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pd_active_r    <= 1'b0;
      pd_precharge_r <= 1'b0;
      pd_pending_r   <= 1'b0;
    end else begin
      pd_pending_r <= (state_r == DPZ_ST_RUN) ? enter_ev
                      : (state_r == DPZ_ST_ENTER) && !exit_ev
                        && (op_busy || cpded_busy);
      if (exit_ev || state_r == DPZ_ST_RUN) begin
        pd_active_r    <= 1'b0;
        pd_precharge_r <= 1'b0;
      end else if (state_r == DPZ_ST_ENTER && !op_busy
                   && !cpded_busy) begin
        pd_active_r    <= any_bank_open;
        pd_precharge_r <= !any_bank_open;
      end
    end
  end

  // Buffers drop on entry; receivers after tCPDED
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      buffers_on_r <= 1'b1;
      cmd_rcv_on_r <= 1'b1;
    end else begin
      if (enter_ev) begin
        buffers_on_r <= 1'b0;
      end else if (exit_ev) begin
        buffers_on_r <= 1'b1;
      end
      if (exit_ev) begin
        cmd_rcv_on_r <= 1'b1;
      end else if (state_r != DPZ_ST_RUN && !enter_ev && !cpded_busy) begin
        cmd_rcv_on_r <= 1'b0;
      end
    end
  end

  // DLL off only for slow-exit precharge power-down
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dll_on_r         <= 1'b1;
      dll_was_locked_r <= 1'b0;
      dll_reset_req_r  <= 1'b0;
    end else begin
      if (enter_ev) begin
        dll_was_locked_r <= dll_locked;
      end
      if (state_r == DPZ_ST_ENTER && !op_busy && !cpded_busy
          && !exit_ev) begin
        dll_on_r <= !slow_mode;
      end else if (exit_ev) begin
        dll_on_r <= 1'b1;
      end
      // Flag for the far side to reset the DLL
      if (exit_ev && !dll_was_locked_r) begin
        dll_reset_req_r <= 1'b1;
      end else if (s2_r.cke && s2_r.cmd == DPZ_CMD_MRS) begin
        dll_reset_req_r <= 1'b0;
      end
    end
  end

  // Exit latency windows; DLL window only matters when slow
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      xp_busy_r    <= 1'b0;
      xpdll_busy_r <= 1'b0;
      zq_busy_r    <= 1'b0;
      zq_done_r    <= 1'b0;
    end else begin
      xp_busy_r    <= xp_busy || exit_ev;
      xpdll_busy_r <= xpdll_busy || exit_ev;
      zq_busy_r    <= zq_busy;
      zq_done_r    <= zq_done;
    end
  end

endmodule : dpz_pd_ctrl

/* File: testbench/dpz_pd_ctrl_asserts.sv */
`timescale 1ns/100ps
module dpz_pd_ctrl_asserts
  import dpz_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       cke_pin,
  input wire logic [2:0] cmd_pin,
  input wire logic       mr0_a12,
  input wire logic       pd_active_r,
  input wire logic       pd_precharge_r,
  input wire logic       buffers_on_r,
  input wire logic       cmd_rcv_on_r,
  input wire logic       dll_on_r,
  input wire logic       xp_busy_r,
  input wire logic       zq_busy_r,
  input wire logic       zq_done_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_entry_buf_off: assert property ($fell(cke_pin) && cmd_pin == 3'h0 &&
    buffers_on_r |-> ##[2:5] !buffers_on_r) else $error("no entry");
  chk_exit_wake_up: assert property ($rose(cke_pin) && !buffers_on_r
    |-> ##[3:6] buffers_on_r) else $error("no exit");
  chk_mode_excl: assert property (!(pd_active_r && pd_precharge_r))
    else $error("both modes");
  chk_rcv_in_pd: assert property (pd_active_r || pd_precharge_r
    |-> !cmd_rcv_on_r && !buffers_on_r) else $error("receivers on");
  chk_rcv_after_buf: assert property (!cmd_rcv_on_r |-> !buffers_on_r)
    else $error("receiver order");
  chk_dll_slow_off: assert property ($fell(dll_on_r)
    |-> !mr0_a12 && !pd_active_r) else $error("dll off wrongly");
  chk_dll_fast_on: assert property (pd_active_r || pd_precharge_r &&
    mr0_a12 |-> dll_on_r) else $error("dll off in fast mode");
  chk_xp_after_exit: assert property ($rose(cmd_rcv_on_r)
    |-> ##[0:1] xp_busy_r) else $error("no exit window");
  chk_zq_bounded: assert property ($rose(zq_busy_r)
    |-> ##[1:40] !zq_busy_r) else $error("calibration too long");
  chk_zq_done_pulse: assert property ($fell(zq_busy_r)
    |-> ##[0:1] zq_done_r) else $error("no value transfer");
endmodule : dpz_pd_ctrl_asserts

bind dpz_pd_ctrl dpz_pd_ctrl_asserts i_chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .cke_pin(cke_pin), .cmd_pin(cmd_pin),
  .mr0_a12(mr0_a12), .pd_active_r(pd_active_r),
  .pd_precharge_r(pd_precharge_r), .buffers_on_r(buffers_on_r),
  .cmd_rcv_on_r(cmd_rcv_on_r), .dll_on_r(dll_on_r),
  .xp_busy_r(xp_busy_r), .zq_busy_r(zq_busy_r), .zq_done_r(zq_done_r));

/* File: testbench/dpz_ctl_model.sv */
`timescale 1ns/100ps
module dpz_ctl_model
  import dpz_pkg::*;
(
  input wire logic    sys_clk,
  output dpz_cmdbus_t bus
);
  // Never enters self-refresh, so no extra refresh is owed
  initial bus = '{cke: 1'b1, cmd: DPZ_CMD_NOP};
  // One command cycle, NOP around every CKE change
  task automatic send(input logic cke, input dpz_cmd_t cmd);
    @(negedge sys_clk);
    bus <= '{cke: cke, cmd: cmd};
    @(negedge sys_clk);
    bus <= '{cke: cke, cmd: DPZ_CMD_NOP};
  endtask : send
endmodule : dpz_ctl_model

/* File: testbench/ddr3_powerdown_zq_control_test.sv */
`timescale 1ns/100ps
module ddr3_powerdown_zq_control_test;
  import dpz_pkg::*;
  logic        sys_clk, reset_n, any_bank_open, bank_op_busy;
  logic        mr0_a12, dll_locked;
  dpz_timing_t tim;
  dpz_cmdbus_t bus;
  logic        pd_active_r, pd_precharge_r, pd_pending_r, buffers_on_r;
  logic        cmd_rcv_on_r, dll_on_r, dll_reset_req_r, xp_busy_r;
  logic        xpdll_busy_r, zq_busy_r, zq_done_r;
  int          mismatches, check_count, seed, n, i;
  dpz_ctl_model i_ctl (.sys_clk(sys_clk), .bus(bus));
  dpz_pd_ctrl i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .cke_pin(bus.cke), .cmd_pin(bus.cmd), .any_bank_open(any_bank_open),
    .bank_op_busy(bank_op_busy), .mr0_a12(mr0_a12),
    .dll_locked(dll_locked), .tim(tim), .pd_active_r(pd_active_r),
    .pd_precharge_r(pd_precharge_r), .pd_pending_r(pd_pending_r),
    .buffers_on_r(buffers_on_r), .cmd_rcv_on_r(cmd_rcv_on_r),
    .dll_on_r(dll_on_r), .dll_reset_req_r(dll_reset_req_r),
    .xp_busy_r(xp_busy_r), .xpdll_busy_r(xpdll_busy_r),
    .zq_busy_r(zq_busy_r), .zq_done_r(zq_done_r));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Active, precharge, DLL running
  function automatic logic [2:0] pd_expect(input logic open, input logic a12);
    return {open, !open, open | a12};
  endfunction : pd_expect
  task automatic wait_pd();
    for (i = 0; i < 100 && pd_active_r !== 1'b1 && pd_precharge_r !== 1'b1;
         i++) @(negedge sys_clk);
    if (i == 100) begin
      mismatches++;
      end_of_test();
    end
  endtask : wait_pd
  task automatic zq_run(input dpz_cmd_t c, input logic [15:0] t);
    int len;
    i_ctl.send(1'b1, c); // Banks closed, channel quiet
    for (i = 0; i < 10 && zq_busy_r !== 1'b1; i++) @(negedge sys_clk);
    for (len = 0; len < 200 && zq_busy_r === 1'b1; len++)
      @(negedge sys_clk);
    check("zq_len", len >= t && len <= t + 1, 16'h0001);
    if (i == 10 || len == 200) end_of_test();
    repeat (4) @(negedge sys_clk);
  endtask : zq_run
  initial begin
    seed = 32'h68a4289a;
    {reset_n, any_bank_open, bank_op_busy, mr0_a12} = 4'h0;
    dll_locked = 1'b1;
    // Random short counts keep runs brief
    tim = '{16'h0004 + 16'($random(seed) & 3), 16'h0008, 16'h0004 +
      16'($random(seed) & 3), 16'h0010, 16'h0018, 16'h000c, 16'h0006};
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    check("rst", {buffers_on_r, cmd_rcv_on_r, dll_on_r, pd_active_r}, 4'he);
    for (n = 0; n < 8; n++) begin
      {mr0_a12, any_bank_open} = n < 4 ? n[1:0] : 2'($random(seed));
      dll_locked = n < 5 ? 1'b1 : 1'($random(seed)); // Unlocked entry
      bank_op_busy = n == 2;
      if (n == 0) i_ctl.send(1'b1, DPZ_CMD_REF); // Refresh running
      i_ctl.send(1'b0, DPZ_CMD_NOP); // Also sent while busy, for n == 0 and n == 2
      if (bank_op_busy || n == 0) begin
        repeat (12) @(negedge sys_clk);
        check("pend", {pd_pending_r, pd_active_r, pd_precharge_r}, 3'h4);
        bank_op_busy = 1'b0;
      end
      wait_pd();
      check("mode", {pd_active_r, pd_precharge_r, dll_on_r},
            pd_expect(any_bank_open, mr0_a12));
      check("bufs", {buffers_on_r, cmd_rcv_on_r}, 2'h0);
      repeat (4) @(negedge sys_clk); // Low past tCKE
      i_ctl.send(1'b1, DPZ_CMD_NOP);
      repeat (4) @(negedge sys_clk);
      check("exit", {buffers_on_r, cmd_rcv_on_r,
            xp_busy_r, xpdll_busy_r}, 4'hf);
      check("dllrst", dll_reset_req_r, !dll_locked);
      repeat (20) @(negedge sys_clk); // Past tXPDLL
      check("xpend", {xp_busy_r, xpdll_busy_r}, 2'h0);
      if (!dll_locked) i_ctl.send(1'b1, DPZ_CMD_MRS);
      repeat (4) @(negedge sys_clk);
      check("dllclr", dll_reset_req_r, 1'b0);
    end
    $display("Test power_down done");
    i_ctl.send(1'b0, DPZ_CMD_NOP);
    wait_pd();
    reset_n = 1'b0;
    @(negedge sys_clk);
    check("pdrst", {pd_active_r, pd_precharge_r, buffers_on_r}, 3'h1);
    reset_n = 1'b1;
    i_ctl.send(1'b1, DPZ_CMD_NOP);
    $display("Test reset_in_pd done");
    zq_run(DPZ_CMD_ZQCL, tim.t_zqinit);
    zq_run(DPZ_CMD_ZQCL, tim.t_zqoper);
    zq_run(DPZ_CMD_ZQCS, tim.t_zqcs);
    $display("Test calibration done");
    end_of_test();
  end
endmodule : ddr3_powerdown_zq_control_test
